// ===== logic/cdff_cfg.svh
// Purpose: constants for the diagnostic frame formatter
// Assumes: 11-bit identifiers, eight-byte frames
// Notes: included by the package and design modules
`ifndef CDFF_CFG_SVH
`define CDFF_CFG_SVH
`define CDFF_TX_ID_RST 11'h7df
`define CDFF_RX_ID_RST 11'h7e0
`define CDFF_RX_MASK_RST 11'h7f0
`define CDFF_PAD_BYTE 8'h00
`define CDFF_FC_BYTE0 8'h30
`define CDFF_FC_BYTE1 8'h00
`define CDFF_FC_BYTE2 8'h00
`define CDFF_FC_OFFSET 11'h008
`define CDFF_MAX_SF 4'h7
`define CDFF_FRAME_BYTES 4'h8
`define CDFF_PCI_SF 4'h0
`define CDFF_PCI_FF 4'h1
`define CDFF_PCI_CF 4'h2
`define CDFF_PCI_FC 4'h3
`endif

// ===== logic/cdff_pkg.sv
// Purpose: types shared by the formatter modules
// Assumes: constants come from cdff_cfg.svh
// Notes: line kinds tell the host text side how to print
`include "cdff_cfg.svh"
package cdff_pkg;
	typedef enum logic [2:0] {
		CDFF_LINE_SINGLE = 3'b000,
		CDFF_LINE_LENGTH = 3'b001,
		CDFF_LINE_SEQ = 3'b010,
		CDFF_LINE_FC = 3'b011,
		CDFF_LINE_RTR = 3'b100,
		CDFF_LINE_RAW = 3'b101
	} cdff_line_t;
	typedef enum logic [1:0] {
		CDFF_TX_IDLE = 2'b00,
		CDFF_TX_SEND = 2'b01
	} cdff_tx_state_t;
endpackage : cdff_pkg

// ===== logic/cdff_id_filter.sv
// Purpose: acceptance filter on 11-bit identifiers
// Assumes: wildcard digits come in as mask nibbles of zero
// Notes: purely combinational
`timescale 1ns/1ps
`include "cdff_cfg.svh"
module cdff_id_filter #(
	parameter int ID_W = 11
) (
	input wire logic [ID_W-1:0] id,
	input wire logic [ID_W-1:0] match_id,
	input wire logic [ID_W-1:0] match_mask,
	output logic accept
);
	assign accept = ((id ^ match_id) & match_mask) == '0;
endmodule : cdff_id_filter

// ===== logic/cdff_seq_slot.sv
// Purpose: reassembly state for one responder
// Assumes: start and step are one-cycle pulses
// Notes: instantiated once per slot
`timescale 1ns/1ps
`include "cdff_cfg.svh"
module cdff_seq_slot (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic start,
	input wire logic step,
	output logic [3:0] seq_q,
	output logic active_q
);
	// digit from 1 to f then wraps to 0
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			seq_q <= 4'h0;
			active_q <= 1'b0;
		end else if (start) begin
			seq_q <= 4'h1;
			active_q <= 1'b1;
		end else if (step) begin
			seq_q <= seq_q + 4'h1;
		end
	end
endmodule : cdff_seq_slot

// ===== logic/cdff_frame_formatter.sv
// Purpose: frames host requests and unframes received CAN frames
// Assumes: CAN controller and host text side are outside; frames are 8-byte vectors
// Notes: reports one line per accepted frame with a kind and digit, except remote or zero-length frames while formatting is on and headers are off
`timescale 1ns/1ps
`include "cdff_cfg.svh"
module cdff_frame_formatter #(
	parameter int SLOTS = 16
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic set_transmit_header_cmd,
	input wire logic [10:0] cmd_id,
	input wire logic set_receive_address_cmd,
	input wire logic [10:0] cmd_mask,
	input wire logic header_display_on_cmd,
	input wire logic header_display_off_cmd,
	input wire logic auto_format_on,
	input wire logic auto_format_off,
	input wire logic req_valid,
	input wire logic [63:0] req_data,
	input wire logic [3:0] req_len,
	output logic req_ready,
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [10:0] tx_id,
	output logic [63:0] tx_data,
	input wire logic rx_valid,
	input wire logic [10:0] rx_id,
	input wire logic rx_rtr,
	input wire logic [3:0] rx_dlc,
	input wire logic [63:0] rx_data,
	output logic line_valid,
	output cdff_pkg::cdff_line_t line_kind,
	output logic [10:0] line_id,
	output logic line_show_id,
	output logic [3:0] line_seq,
	output logic [11:0] line_total,
	output logic [63:0] line_data,
	output logic [3:0] line_count,
	output logic hdr_on,
	output logic fmt_on
);
	import cdff_pkg::*;
	// ==========================================
	// configuration
	logic [10:0] tx_id_q;
	logic [10:0] rx_id_q;
	logic [10:0] rx_mask_q;
	logic hdr_q;
	logic fmt_q;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_id_q <= `CDFF_TX_ID_RST;
		end else if (set_transmit_header_cmd) begin
			tx_id_q <= cmd_id;
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rx_id_q <= `CDFF_RX_ID_RST;
			rx_mask_q <= `CDFF_RX_MASK_RST;
		end else if (set_receive_address_cmd) begin
			rx_id_q <= cmd_id;
			rx_mask_q <= cmd_mask;
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			hdr_q <= 1'b0;
			fmt_q <= 1'b1;
		end else begin
			if (header_display_on_cmd) begin
				hdr_q <= 1'b1;
			end else if (header_display_off_cmd) begin
				hdr_q <= 1'b0;
			end
			if (auto_format_on) begin
				fmt_q <= 1'b1;
			end else if (auto_format_off) begin
				fmt_q <= 1'b0;
			end
		end
	end
	assign hdr_on = hdr_q;
	assign fmt_on = fmt_q;
	// ==========================================
	// receive classification
	logic accept;
	logic [3:0] pci_type;
	logic is_rtr;
	logic [3:0] slot;
	cdff_id_filter #(.ID_W(11)) u_filter (
		.id(rx_id),
		.match_id(rx_id_q),
		.match_mask(rx_mask_q),
		.accept(accept)
	);
	assign pci_type = rx_data[63:60];
	assign is_rtr = rx_rtr || (rx_dlc == 4'h0);
	assign slot = rx_id[3:0];
	logic rx_take;
	logic rx_ff;
	logic rx_cf;
	assign rx_take = rx_valid && accept;
	assign rx_ff = rx_take && !is_rtr && (pci_type == `CDFF_PCI_FF);
	assign rx_cf = rx_take && !is_rtr && (pci_type == `CDFF_PCI_CF);
	// ==========================================
	// per-responder reassembly
	logic [SLOTS-1:0] slot_start;
	logic [SLOTS-1:0] slot_step;
	logic [3:0] slot_seq [SLOTS];
	logic [SLOTS-1:0] slot_act;
	genvar gi;
	generate
		for (gi = 0; gi < SLOTS; gi++) begin : g_slot
			assign slot_start[gi] = rx_ff && (slot == 4'(gi));
			assign slot_step[gi] = rx_cf && (slot == 4'(gi));
			cdff_seq_slot u_slot (
				.clk(clk),
				.sys_rst(sys_rst),
				.start(slot_start[gi]),
				.step(slot_step[gi]),
				.seq_q(slot_seq[gi]),
				.active_q(slot_act[gi])
			);
		end
	endgenerate
	// ==========================================
	// report lines
	logic lv_q;
	cdff_line_t lk_q;
	logic [10:0] lid_q;
	logic lshow_q;
	logic [3:0] lseq_q;
	logic [11:0] ltot_q;
	logic [63:0] ld_q;
	logic [3:0] lc_q;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			lv_q <= 1'b0;
			lk_q <= CDFF_LINE_SINGLE;
			lid_q <= 11'h000;
			lshow_q <= 1'b0;
			lseq_q <= 4'h0;
			ltot_q <= 12'h000;
			ld_q <= 64'h0;
			lc_q <= 4'h0;
		end else begin
			lv_q <= 1'b0;
			if (rx_take && !(is_rtr && fmt_q && !hdr_q)) begin
				lv_q <= 1'b1;
				lid_q <= rx_id;
				lshow_q <= hdr_q;
				lseq_q <= 4'h0;
				ltot_q <= 12'h000;
				ld_q <= rx_data;
				lc_q <= rx_dlc;
				if (is_rtr) begin
					lk_q <= CDFF_LINE_RTR;
					lc_q <= 4'h0;
				end else if (pci_type == `CDFF_PCI_FC) begin
					lk_q <= CDFF_LINE_FC;
				end else if (!fmt_q || hdr_q) begin
					lk_q <= CDFF_LINE_RAW;
				end else if (pci_type == `CDFF_PCI_FF) begin
					lk_q <= CDFF_LINE_LENGTH;
					ltot_q <= rx_data[59:48];
					ld_q <= {rx_data[47:0], 16'h0};
					lc_q <= 4'h6;
				end else if (pci_type == `CDFF_PCI_CF) begin
					lk_q <= CDFF_LINE_SEQ;
					lseq_q <= slot_seq[slot];
					ld_q <= {rx_data[55:0], 8'h0};
					lc_q <= 4'h7;
				end else begin
					lk_q <= CDFF_LINE_SINGLE;
					ld_q <= {rx_data[55:0], 8'h0};
					lc_q <= (rx_data[59:56] > `CDFF_MAX_SF) ? `CDFF_MAX_SF : rx_data[59:56];
				end
			end
		end
	end
	assign line_valid = lv_q;
	assign line_kind = lk_q;
	assign line_id = lid_q;
	assign line_show_id = lshow_q;
	assign line_seq = lseq_q;
	assign line_total = ltot_q;
	assign line_data = ld_q;
	assign line_count = lc_q;
	// ==========================================
	// transmit path
	cdff_tx_state_t st_q;
	logic [10:0] txid_q;
	logic [63:0] txd_q;
	logic fc_pend_q;
	logic [10:0] fc_id_q;
	logic [63:0] pad_mask;
	logic [63:0] req_body;
	logic [3:0] sf_len;
	// flow control pending after first frame
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			fc_pend_q <= 1'b0;
			fc_id_q <= 11'h000;
		end else if (rx_ff) begin
			fc_pend_q <= 1'b1;
			fc_id_q <= rx_id - `CDFF_FC_OFFSET;
		end else if (st_q == CDFF_TX_IDLE) begin
			fc_pend_q <= 1'b0;
		end
	end
	assign sf_len = (req_len > `CDFF_MAX_SF) ? `CDFF_MAX_SF : req_len;
	always_comb begin
		pad_mask = '1;
		if (fmt_q) begin
			pad_mask = ~(64'hffffffffffffffff >> {sf_len, 3'b000});
			req_body = {4'h0, sf_len, req_data[63:8]};
			pad_mask = {8'hff, pad_mask[63:8]};
		end else begin
			pad_mask = (req_len >= `CDFF_FRAME_BYTES) ? 64'hffffffffffffffff
				: ~(64'hffffffffffffffff >> {req_len, 3'b000});
			req_body = req_data;
		end
	end
	assign req_ready = (st_q == CDFF_TX_IDLE) && !fc_pend_q && !rx_ff;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q <= CDFF_TX_IDLE;
			txid_q <= 11'h000;
			txd_q <= 64'h0;
		end else begin
			case (st_q)
				CDFF_TX_IDLE: begin
					if (fc_pend_q) begin
						txid_q <= fc_id_q;
						txd_q <= {`CDFF_FC_BYTE0, `CDFF_FC_BYTE1, `CDFF_FC_BYTE2, {5{`CDFF_PAD_BYTE}}};
						st_q <= CDFF_TX_SEND;
					end else if (req_valid && req_ready) begin
						txid_q <= tx_id_q;
						txd_q <= (req_body & pad_mask) | ({8{`CDFF_PAD_BYTE}} & ~pad_mask);
						st_q <= CDFF_TX_SEND;
					end
				end
				CDFF_TX_SEND: begin
					if (tx_ready) begin
						st_q <= CDFF_TX_IDLE;
					end
				end
				default: begin
					st_q <= CDFF_TX_IDLE;
				end
			endcase
		end
	end
	assign tx_valid = (st_q == CDFF_TX_SEND);
	assign tx_id = txid_q;
	assign tx_data = txd_q;
	// ==========================================
	// checks
	AST_FILTER_GATES: assert property (@(posedge clk) disable iff (sys_rst)
		(rx_valid && !accept) |=> !line_valid) else $error("rejected frame reported");
	AST_RTR_HIDDEN: assert property (@(posedge clk) disable iff (sys_rst)
		(line_valid && line_kind == CDFF_LINE_RTR) |-> ($past(hdr_q) || !$past(fmt_q)))
		else $error("remote marker while hidden");
	AST_FC_FOLLOWS: assert property (@(posedge clk) disable iff (sys_rst)
		(rx_ff && st_q == CDFF_TX_IDLE && !fc_pend_q) |=> ##1 (tx_valid && tx_data[63:56] == `CDFF_FC_BYTE0))
		else $error("flow control not sent");
	AST_TX_ID: assert property (@(posedge clk) disable iff (sys_rst)
		(req_valid && req_ready) |=> (tx_valid && tx_id == $past(tx_id_q))) else $error("wrong transmit id");
	AST_SF_PCI: assert property (@(posedge clk) disable iff (sys_rst)
		(req_valid && req_ready && fmt_q) |=> tx_data[63:56] == {4'h0, $past(sf_len)})
		else $error("bad single frame byte");
	AST_TX_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
		(tx_valid && !tx_ready) |=> (tx_valid && $stable(tx_data))) else $error("frame changed while stalled");
	AST_LEN_LINE: assert property (@(posedge clk) disable iff (sys_rst)
		(rx_ff && accept && fmt_q && !hdr_q) |=> (line_kind == CDFF_LINE_LENGTH && line_total == $past(rx_data[59:48])))
		else $error("length line wrong");
	AST_HDR_SHOW: assert property (@(posedge clk) disable iff (sys_rst)
		line_valid |-> line_show_id == $past(hdr_q)) else $error("id display mismatch");
endmodule : cdff_frame_formatter

// ===== verification/cdff_ecu_model.sv
// Purpose: responder-side stand-in that takes request frames off the bus
// Assumes: one frame per tx handshake
// Notes: stall holds tx_ready low to act as a slow, busy bus
`timescale 1ns/1ps
module cdff_ecu_model (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic stall,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [10:0] tx_id,
	input wire logic [63:0] tx_data,
	output logic [10:0] got_id,
	output logic [63:0] got_data,
	output logic [7:0] n_got
);
	// ==========================
	// frame acceptance
	assign tx_ready = !stall;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			n_got <= 8'h00;
		end else if (tx_valid && tx_ready) begin
			got_id <= tx_id;
			got_data <= tx_data;
			n_got <= n_got + 8'h01;
		end
	end
endmodule : cdff_ecu_model

// ===== verification/cdff_frame_formatter_bench.sv
// Purpose: self-checking bench for the frame formatter
// Assumes: responder model takes every request frame
// Notes: row table covers default mode, hand tests cover mode changes
`timescale 1ns/1ps
module cdff_frame_formatter_bench;
	import cdff_pkg::*;
	typedef struct {logic [10:0] id; logic r; logic [3:0] n; logic [63:0] d; logic v; cdff_line_t k;
		logic [11:0] a;} cdff_row_t;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic stall = 1'b0;
	logic [5:0] cmd_v = 6'h00;
	logic [10:0] cmd_id = 11'h000;
	logic [10:0] cmd_mask = 11'h000;
	logic req_valid = 1'b0;
	logic [63:0] req_data = 64'h0;
	logic [3:0] req_len = 4'h0;
	logic rx_valid = 1'b0;
	logic [10:0] rx_id = 11'h000;
	logic rx_rtr = 1'b0;
	logic [3:0] rx_dlc = 4'h0;
	logic [63:0] rx_data = 64'h0;
	logic req_ready, tx_valid, tx_ready, line_valid, line_show_id, hdr_on, fmt_on;
	logic [10:0] tx_id, line_id, got_id;
	logic [63:0] tx_data, line_data, got_data;
	cdff_line_t line_kind;
	logic [3:0] line_seq, line_count;
	logic [11:0] line_total;
	logic [7:0] n_got;
	int n_errors = 0;
	int compares = 0;
	cdff_row_t rows [9];

	always #5 clk = ~clk;

	cdff_frame_formatter u_cdff_frame_formatter (.clk(clk), .sys_rst(sys_rst),
		.set_transmit_header_cmd(cmd_v[0]), .cmd_id(cmd_id), .set_receive_address_cmd(cmd_v[1]),
		.cmd_mask(cmd_mask), .header_display_on_cmd(cmd_v[2]), .header_display_off_cmd(cmd_v[3]),
		.auto_format_on(cmd_v[4]), .auto_format_off(cmd_v[5]), .req_valid(req_valid),
		.req_data(req_data), .req_len(req_len), .req_ready(req_ready), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .tx_id(tx_id), .tx_data(tx_data), .rx_valid(rx_valid), .rx_id(rx_id),
		.rx_rtr(rx_rtr), .rx_dlc(rx_dlc), .rx_data(rx_data), .line_valid(line_valid),
		.line_kind(line_kind), .line_id(line_id), .line_show_id(line_show_id), .line_seq(line_seq),
		.line_total(line_total), .line_data(line_data), .line_count(line_count), .hdr_on(hdr_on),
		.fmt_on(fmt_on));

	cdff_ecu_model u_cdff_ecu_model (.clk(clk), .sys_rst(sys_rst), .stall(stall), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .tx_id(tx_id), .tx_data(tx_data), .got_id(got_id), .got_data(got_data),
		.n_got(n_got));

	// ==========================
	// checking and closing
	task automatic chk(input logic [75:0] got, input logic [75:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic close_out;
		$display("mismatches %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : close_out

	// ==========================
	// drivers
	task automatic cmd(input logic [5:0] v, input logic [10:0] id, input logic [10:0] m);
		@(posedge clk);
		cmd_v <= v;
		cmd_id <= id;
		cmd_mask <= m;
		@(posedge clk);
		cmd_v <= 6'h00;
	endtask : cmd

	task automatic rx(input cdff_row_t w);
		@(posedge clk);
		rx_valid <= 1'b1;
		rx_id <= w.id;
		rx_rtr <= w.r;
		rx_dlc <= w.n;
		rx_data <= w.d;
		@(posedge clk);
		rx_valid <= 1'b0;
		#1;
		chk(line_valid, w.v);
		if (w.v) begin
			chk(line_kind, w.k);
			case (w.k)
				CDFF_LINE_SINGLE: chk({line_count, line_data[63:16]}, {w.a[3:0], w.d[55:8]});
				CDFF_LINE_LENGTH: chk({line_count, line_total, line_data[63:16]}, {4'h6, w.a, w.d[47:0]});
				CDFF_LINE_SEQ: chk({line_count, line_seq, line_data[63:8]}, {4'h7, w.a[3:0], w.d[55:0]});
				CDFF_LINE_FC: chk(line_data, w.d);
				CDFF_LINE_RTR: chk(line_count, 4'h0);
				CDFF_LINE_RAW: chk({line_show_id, line_id, line_data}, {1'b1, w.id, w.d});
				default: ;
			endcase
		end
	endtask : rx

	task automatic req(input logic [63:0] d, input logic [3:0] n, input logic [63:0] e, input logic [10:0] id);
		int i;
		logic [7:0] c0;
		c0 = n_got;
		@(posedge clk);
		req_valid <= 1'b1;
		req_data <= d;
		req_len <= n;
		@(posedge clk);
		req_valid <= 1'b0;
		for (i = 0; i < 50 && n_got == c0; i++) begin
			@(posedge clk);
			#1;
		end
		chk({got_id, got_data}, {id, e});
	endtask : req

	// ==========================
	// main sequence
	initial begin
		rows = '{'{11'h7e8, 0, 8, 64'h064100be3fb81300, 1, CDFF_LINE_SINGLE, 6},
			'{11'h7d8, 0, 8, 64'h0641000000000000, 0, CDFF_LINE_SINGLE, 0},
			'{11'h7e9, 1, 8, 64'h0, 0, CDFF_LINE_RTR, 0},
			'{11'h7e8, 0, 8, 64'h3000000000000000, 1, CDFF_LINE_FC, 0},
			'{11'h7e8, 0, 8, 64'h1014490201314434, 1, CDFF_LINE_LENGTH, 12'h014},
			'{11'h7e8, 0, 8, 64'h2147503030523535, 1, CDFF_LINE_SEQ, 1},
			'{11'h7e9, 0, 8, 64'h1fff490201314434, 1, CDFF_LINE_LENGTH, 12'hfff},
			'{11'h7e8, 0, 8, 64'h2242313233343536, 1, CDFF_LINE_SEQ, 2},
			'{11'h7e9, 0, 8, 64'h2132383935344143, 1, CDFF_LINE_SEQ, 1}};
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		#1;
		chk({req_ready, fmt_on, hdr_on, tx_valid, line_valid}, 5'b11000);
		foreach (rows[i]) rx(rows[i]);
		repeat (4) @(posedge clk);
		chk({n_got, got_id, got_data}, {8'h02, 11'h7e1, 64'h3000000000000000});
		cmd(6'h01, 11'h7e0, 11'h000);
		stall <= 1'b1;
		fork
			req(64'h010d112233445566, 2, 64'h02010d0000000000, 11'h7e0);
			begin
				repeat (4) @(posedge clk);
				chk({tx_valid, tx_id}, {1'b1, 11'h7e0});
				@(posedge clk);
				stall <= 1'b0;
			end
		join
		cmd(6'h20, 11'h000, 11'h000);
		req(64'h0322f190aabbccdd, 4, 64'h0322f19000000000, 11'h7e0);
		rx(cdff_row_t'{11'h7e8, 1, 8, 64'h0, 1, CDFF_LINE_RTR, 0});
		rx(cdff_row_t'{11'h7e8, 0, 0, 64'h0, 1, CDFF_LINE_RTR, 0});
		cmd(6'h04, 11'h000, 11'h000);
		rx(cdff_row_t'{11'h7e8, 0, 8, 64'h064100be3fb81300, 1, CDFF_LINE_RAW, 0});
		cmd(6'h02, 11'h7c0, 11'h7f0);
		rx(cdff_row_t'{11'h7cf, 0, 8, 64'h0241050000000000, 1, CDFF_LINE_RAW, 0});
		rx(cdff_row_t'{11'h7e8, 0, 8, 64'h0241050000000000, 0, CDFF_LINE_RAW, 0});
		// headers off and formatting back on
		cmd(6'h18, 11'h000, 11'h000);
		#1;
		chk({hdr_on, fmt_on}, 2'b01);
		close_out;
	end

	// ==========================
	// watchdog
	initial begin
		#100000;
		n_errors++;
		close_out;
	end
endmodule : cdff_frame_formatter_bench
